// *** bench/ipd_core_model.sv ***
// Processor core model: takes offers, tracks its level, supplies context
`timescale 1ns/10ps
module ipd_core_model import ipd_pkg::*; (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic int_req_i,
  input wire logic taken_i,
  input wire logic halt_i,
  input wire logic [4:0] new_level_i,
  input wire logic ack_en_i,
  input wire logic [2:0] ack_dly_i,
  input wire logic lvl_load_i,
  input wire logic [4:0] lvl_val_i,
  output logic core_ack_o,
  output logic [4:0] cpl_o,
  output ipd_ctx_t ctx_o
);
  logic [2:0] wait_r;
  logic [31:0] pc_r;

  // Status word carries the level so a halt save can be seen in it
  assign ctx_o = {pc_r, 27'h0000000, cpl_o};

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_ack_o <= 1'b0;
      cpl_o <= 5'h00;
      pc_r <= 32'h00000000;
      wait_r <= 3'h0;
    end else begin
      core_ack_o <= 1'b0;
      if (lvl_load_i) begin
        cpl_o <= lvl_val_i;
      end else if (taken_i || halt_i) begin
        cpl_o <= new_level_i;
      end
      if (taken_i || halt_i) begin
        pc_r <= pc_r + 32'h00000001;
      end
      // Slow answers: wait ack_dly_i cycles of a standing offer
      if (int_req_i && ack_en_i && !core_ack_o) begin
        if (wait_r == ack_dly_i) begin
          core_ack_o <= 1'b1;
          wait_r <= 3'h0;
        end else begin
          wait_r <= wait_r + 3'h1;
        end
      end else begin
        wait_r <= 3'h0;
      end
    end
  end
endmodule

// *** bench/ipd_dispatch_tb.sv ***
// Self-checking testbench of the priority dispatch block
`timescale 1ns/10ps
`include "ipd_cfg.svh"
module ipd_dispatch_tb import ipd_pkg::*; ;
  typedef struct packed {
    logic [9:0] e1d;
    logic [17:0] e1a;
    logic perf;
    logic tmr;
    logic net;
    logic [3:0] irq;
    logic [15:1] sw;
    logic [4:0] lvl;
    logic [9:0] vec;
    logic intl;
  } ipd_row_t;

  logic core_clk_i = 1'b0, arst_n_i = 1'b0, halt_req_i = 1'b0;
  logic [9:0] err_1d_i = 10'h000;
  logic [17:0] err_1a_i = 18'h00000;
  logic perf_mon_i = 1'b0, timer_i = 1'b0, net_i = 1'b0;
  logic [3:0] irq_i = 4'h0;
  logic [15:1] sw_req_i = 15'h0000;
  logic exc_valid_i = 1'b0, exc_abort_i = 1'b0;
  ipd_exc_t exc_code_i = EXC_INT_OVF;
  logic core_ack_i, int_req_o, int_internal_o, taken_o, halt_o, exc_valid_o;
  logic [4:0] cpl, int_level_o, new_level_o;
  logic [9:0] int_vector_o;
  logic [3:0] halt_code_o;
  ipd_ctx_t ctx_i, saved_ctx_o;
  ipd_class_t exc_class_o;
  logic ack_en = 1'b0, lvl_load = 1'b0;
  logic [2:0] ack_dly = 3'h0;
  logic [4:0] lvl_val = 5'h00;
  int n_mismatch = 0, samples_checked = 0, n_take = 0;
  ipd_row_t rows [11];

  always #5 core_clk_i = ~core_clk_i;

  ipd_dispatch u_ipd_dispatch (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .halt_req_i(halt_req_i), .err_1d_i(err_1d_i), .err_1a_i(err_1a_i),
    .perf_mon_i(perf_mon_i), .irq_i(irq_i), .timer_i(timer_i), .net_i(net_i),
    .sw_req_i(sw_req_i), .current_priority_level_i(cpl),
    .core_ack_i(core_ack_i), .ctx_i(ctx_i), .exc_valid_i(exc_valid_i),
    .exc_code_i(exc_code_i), .exc_abort_i(exc_abort_i),
    .int_req_o(int_req_o), .int_level_o(int_level_o),
    .int_vector_o(int_vector_o), .int_internal_o(int_internal_o),
    .taken_o(taken_o), .halt_o(halt_o), .halt_code_o(halt_code_o),
    .new_level_o(new_level_o), .saved_ctx_o(saved_ctx_o),
    .exc_valid_o(exc_valid_o), .exc_class_o(exc_class_o));

  ipd_core_model u_ipd_core_model (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .int_req_i(int_req_o), .taken_i(taken_o),
    .halt_i(halt_o), .new_level_i(new_level_o), .ack_en_i(ack_en),
    .ack_dly_i(ack_dly), .lvl_load_i(lvl_load), .lvl_val_i(lvl_val),
    .core_ack_o(core_ack_i), .cpl_o(cpl), .ctx_o(ctx_i));

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait: 0 offer, 1 take, 2 halt
  task automatic wait_for(input int w);
    int i;
    for (i = 0; i < 30; i++) begin
      @(negedge core_clk_i);
      if ((w == 0 && int_req_o === 1'b1) || (w == 1 && taken_o === 1'b1) ||
          (w == 2 && halt_o === 1'b1)) return;
    end
    n_mismatch++;
    conclude();
  endtask

  task automatic set_lvl(input logic [4:0] v);
    @(negedge core_clk_i);
    lvl_val = v;
    lvl_load = 1'b1;
    @(negedge core_clk_i);
    lvl_load = 1'b0;
  endtask

  task automatic take(input logic [4:0] lvl, input logic [9:0] vec);
    wait_for(0);
    check(int_level_o, lvl);
    check(int_vector_o, vec);
    ack_en = 1'b1;
    wait_for(1);
    ack_en = 1'b0;
    check(new_level_o, lvl);
    check(saved_ctx_o.pc, n_take);
    check(int_req_o, 1'b0);
    n_take++;
  endtask

  function automatic ipd_class_t exp_class(input ipd_exc_t c, input logic ab);
    case (c)
      EXC_INT_OVF, EXC_INT_DIV0, EXC_SUBRNG: return {CAT_ARITH, KIND_TRAP};
      EXC_FLT_OVF, EXC_FLT_DIV0, EXC_FLT_UNF: return {CAT_ARITH, KIND_FAULT};
      EXC_ACV, EXC_TNV, EXC_MOD_CLR: return {CAT_MEMMGT, KIND_FAULT};
      EXC_RSV_MODE: return {CAT_OPERAND, KIND_FAULT};
      EXC_RSV_OPND: return {CAT_OPERAND, ab ? KIND_ABORT : KIND_FAULT};
      EXC_CHMODE: return {CAT_INSTR, KIND_TRAP};
      EXC_TRACE: return {CAT_TRACE, KIND_FAULT};
      EXC_KSNV, EXC_MCHK: return {CAT_SYSFAIL, KIND_ABORT};
      EXC_ISNV, EXC_CONS_ERR: return {CAT_SYSFAIL, KIND_HALT};
      default: return {CAT_INSTR, KIND_FAULT};
    endcase
  endfunction

  initial begin
    int r, c;
    // Middle group is {perf, timer, net, irq[3:0]}
    rows[0] = {10'h001, 18'h0, 7'h00, 15'h0, 5'h1d, 10'h060, 1'b0};
    rows[1] = {10'h200, 18'h0, 7'h00, 15'h0, 5'h1d, 10'h060, 1'b0};
    rows[2] = {10'h0, 18'h00001, 7'h00, 15'h0, 5'h1a, 10'h054, 1'b0};
    rows[3] = {10'h0, 18'h20000, 7'h00, 15'h0, 5'h1a, 10'h054, 1'b0};
    rows[4] = {10'h0, 18'h0, 7'h40, 15'h0, 5'h1b, 10'h000, 1'b1};
    rows[5] = {10'h0, 18'h0, 7'h20, 15'h0, 5'h16, 10'h0c0, 1'b0};
    rows[6] = {10'h0, 18'h0, 7'h10, 15'h0, 5'h13, 10'h104, 1'b0};
    rows[7] = {10'h0, 18'h0, 7'h08, 15'h0, 5'h17, 10'h000, 1'b0};
    rows[8] = {10'h0, 18'h0, 7'h01, 15'h0, 5'h14, 10'h000, 1'b0};
    rows[9] = {10'h0, 18'h0, 7'h00, 15'h4000, 5'h0f, 10'h0bc, 1'b0};
    rows[10] = {10'h0, 18'h0, 7'h00, 15'h0001, 5'h01, 10'h084, 1'b0};
    repeat (2) @(negedge core_clk_i);
    arst_n_i = 1'b1;
    check(halt_code_o, 4'h2);
    check({int_req_o, taken_o, halt_o, new_level_o}, 8'h00);
    check(saved_ctx_o, 64'h0);
    for (r = 0; r < 11; r++) begin
      @(negedge core_clk_i);
      err_1d_i = rows[r].e1d;
      err_1a_i = rows[r].e1a;
      perf_mon_i = rows[r].perf;
      timer_i = rows[r].tmr;
      net_i = rows[r].net;
      irq_i = rows[r].irq;
      sw_req_i = rows[r].sw;
      repeat (2) @(negedge core_clk_i);
      {err_1d_i, err_1a_i, perf_mon_i, timer_i, net_i} = '0;
      take(rows[r].lvl, rows[r].vec);
      check(int_internal_o, rows[r].intl);
      irq_i = 4'h0;
      sw_req_i = 15'h0000;
      repeat (6) @(negedge core_clk_i);
      set_lvl(5'h00);
    end
    // Only strictly above the current level is offered
    set_lvl(5'h1d);
    err_1d_i = 10'h008;
    repeat (2) @(negedge core_clk_i);
    err_1d_i = 10'h000;
    repeat (8) @(negedge core_clk_i);
    check(int_req_o, 1'b0);
    set_lvl(5'h1c);
    ack_dly = 3'h3;
    take(5'h1d, 10'h060);
    ack_dly = 3'h0;
    set_lvl(5'h00);
    // Simultaneous requests taken highest first
    @(negedge core_clk_i);
    err_1a_i = 18'h00020;
    err_1d_i = 10'h004;
    timer_i = 1'b1;
    irq_i = 4'h4;
    repeat (2) @(negedge core_clk_i);
    {err_1a_i, err_1d_i, timer_i} = '0;
    take(5'h1d, 10'h060);
    set_lvl(5'h00);
    take(5'h1a, 10'h054);
    set_lvl(5'h00);
    take(5'h16, 10'h000);
    irq_i = 4'h0;
    repeat (6) @(negedge core_clk_i);
    set_lvl(5'h15);
    take(5'h16, 10'h0c0);
    // Halt at top level, beside a pending error and a willing core
    set_lvl(5'h1f);
    ack_en = 1'b1;
    halt_req_i = 1'b1;
    err_1d_i = 10'h002;
    repeat (2) @(negedge core_clk_i);
    {halt_req_i, err_1d_i} = '0;
    wait_for(2);
    ack_en = 1'b0;
    check(new_level_o, 5'h1f);
    check(saved_ctx_o, {n_take, 32'h0000001f});
    check({taken_o, int_req_o}, 2'h0);
    check(halt_code_o, 4'h2);
    n_take++;
    set_lvl(5'h00);
    take(5'h1d, 10'h060);
    // Exceptions back to back, reserved operand both ways
    for (c = 0; c < 23; c++) begin
      exc_valid_i = 1'b1;
      exc_code_i = (c < 22) ? ipd_exc_t'(c[4:0]) : EXC_RSV_OPND;
      exc_abort_i = (c == 22);
      @(negedge core_clk_i);
      check(exc_valid_o, 1'b1);
      check(exc_class_o, exp_class(exc_code_i, exc_abort_i));
    end
    exc_valid_i = 1'b0;
    @(negedge core_clk_i);
    check(exc_valid_o, 1'b0);
    conclude();
  end
endmodule

// *** core/ipd_dispatch.sv ***
// Interrupt priority arbitration, vector dispatch and exception classes
`timescale 1ns/10ps
`include "ipd_cfg.svh"
module ipd_dispatch import ipd_pkg::*; (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic halt_req_i,
  input wire logic [`IPD_N1D-1:0] err_1d_i,
  input wire logic [`IPD_N1A-1:0] err_1a_i,
  input wire logic perf_mon_i,
  input wire logic [3:0] irq_i,
  input wire logic timer_i,
  input wire logic net_i,
  input wire logic [15:1] sw_req_i,
  input wire logic [4:0] current_priority_level_i,
  input wire logic core_ack_i,
  input ipd_ctx_t ctx_i,
  input wire logic exc_valid_i,
  input ipd_exc_t exc_code_i,
  input wire logic exc_abort_i,
  output logic int_req_o,
  output logic [4:0] int_level_o,
  output logic [9:0] int_vector_o,
  output logic int_internal_o,
  output logic taken_o,
  output logic halt_o,
  output logic [3:0] halt_code_o,
  output logic [4:0] new_level_o,
  output ipd_ctx_t saved_ctx_o,
  output logic exc_valid_o,
  output ipd_class_t exc_class_o
);

  // ------------------------------------------------------------------
  // Sources
  // ------------------------------------------------------------------
  logic halt_pend;
  logic [`IPD_N1D-1:0] pend_1d;
  logic [`IPD_N1A-1:0] pend_1a;
  logic perf_pend;
  logic [3:0] irq_lvl;
  logic timer_pend;
  logic net_pend;
  logic take;
  ipd_offer_t off_r;

  // Halt cell clears on the cycle it is taken, never gated by level
  ipd_src_cell #(.W(1), .STICKY(1'b1)) u_halt (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .raw_i(halt_req_i),
    .clr_i(halt_pend),
    .pend_o(halt_pend)
  );

  // One vector per group; the handler reads the event indicators
  ipd_src_cell #(.W(`IPD_N1D), .STICKY(1'b1)) u_err_1d (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .raw_i(err_1d_i),
    .clr_i(take && off_r.src == SRC_1D),
    .pend_o(pend_1d)
  );

  ipd_src_cell #(.W(`IPD_N1A), .STICKY(1'b1)) u_err_1a (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .raw_i(err_1a_i),
    .clr_i(take && off_r.src == SRC_1A),
    .pend_o(pend_1a)
  );

  ipd_src_cell #(.W(1), .STICKY(1'b1)) u_perf (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .raw_i(perf_mon_i),
    .clr_i(take && off_r.src == SRC_PERF),
    .pend_o(perf_pend)
  );

  // Request lines are levels; the requester drops them itself
  ipd_src_cell #(.W(4), .STICKY(1'b0)) u_irq (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .raw_i(irq_i),
    .clr_i(1'b0),
    .pend_o(irq_lvl)
  );

  ipd_src_cell #(.W(1), .STICKY(1'b1)) u_timer (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .raw_i(timer_i),
    .clr_i(take && off_r.src == SRC_TIMER),
    .pend_o(timer_pend)
  );

  ipd_src_cell #(.W(1), .STICKY(1'b1)) u_net (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .raw_i(net_i),
    .clr_i(take && off_r.src == SRC_NET),
    .pend_o(net_pend)
  );

  // ------------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------------
  function automatic ipd_offer_t arbitrate(
    input logic p1d, input logic pperf, input logic p1a,
    input logic [3:0] irq, input logic tmr, input logic net,
    input logic [15:1] sw);
    ipd_offer_t o;
    o = '{`IPD_LVL_NONE, `IPD_VEC_NONE, 1'b0, SRC_NONE};
    for (int i = 1; i < 16; i++) begin
      if (sw[i]) begin
        o.lvl = 5'(i);
        o.vec = `IPD_VEC_SW_BASE + {4'h0, 4'(i), 2'b00};
        o.src = SRC_SW;
      end
    end
    if (p1d) begin
      o = '{`IPD_LVL_1D, `IPD_VEC_1D, 1'b0, SRC_1D}; // [R2] [R3] [R4] [R5]
    end else if (pperf) begin
      o = '{`IPD_LVL_PERF, `IPD_VEC_NONE, 1'b1, SRC_PERF}; // [R12]
    end else if (p1a) begin
      o = '{`IPD_LVL_1A, `IPD_VEC_1A, 1'b0, SRC_1A}; // [R6] [R7] [R8] [R9]
    end else if (irq[3]) begin
      o = '{`IPD_LVL_IRQ3, `IPD_VEC_NONE, 1'b0, SRC_IRQ3};
    end else if (irq[2]) begin
      o = '{`IPD_LVL_IRQ2, `IPD_VEC_NONE, 1'b0, SRC_IRQ2}; // [R13]
    end else if (tmr) begin
      o = '{`IPD_LVL_TIMER, `IPD_VEC_TIMER, 1'b0, SRC_TIMER}; // [R13]
    end else if (irq[1]) begin
      o = '{`IPD_LVL_IRQ1, `IPD_VEC_NONE, 1'b0, SRC_IRQ1};
    end else if (irq[0]) begin
      o = '{`IPD_LVL_IRQ0, `IPD_VEC_NONE, 1'b0, SRC_IRQ0};
    end else if (net && o.lvl < `IPD_LVL_NET) begin
      o = '{`IPD_LVL_NET, `IPD_VEC_NET, 1'b0, SRC_NET};
    end
    return o;
  endfunction

  ipd_offer_t best;
  logic best_ok;

  // Group OR: I/O read errors and leftovers share the 1A vector
  assign best = arbitrate(|pend_1d, perf_pend, |pend_1a, irq_lvl,
                          timer_pend, net_pend, sw_req_i); // [R10] [R11]
  assign best_ok = best.src != SRC_NONE &&
                   best.lvl > current_priority_level_i; // [R20]

  // ------------------------------------------------------------------
  // Offer and take
  // ------------------------------------------------------------------
  typedef enum logic {S_IDLE, S_OFFER} ipd_state_t;
  ipd_state_t state_r;
  ipd_state_t state_nxt;
  ipd_offer_t off_nxt;
  logic taken_r;
  logic halt_r;
  logic [4:0] new_level_r;
  ipd_ctx_t saved_r;

  // A pending halt pre-empts any offer on the same edge
  assign take = state_r == S_OFFER && core_ack_i && !halt_pend;
  // Core raises its level from taken_o/halt_o, so wait one more cycle
  // rather than offer against a level that is about to change [R20]
  assign state_nxt = (halt_pend || halt_r || taken_r || take || !best_ok) ?
                     S_IDLE : S_OFFER;
  // Offer follows the best request, so a higher one replaces it
  assign off_nxt = best_ok ? best : off_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= S_IDLE;
      off_r <= '{`IPD_LVL_NONE, `IPD_VEC_NONE, 1'b0, SRC_NONE};
    end else begin
      state_r <= state_nxt;
      off_r <= off_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      taken_r <= 1'b0;
      halt_r <= 1'b0;
      new_level_r <= `IPD_LVL_NONE;
      saved_r <= '{`IPD_RST_CTX, `IPD_RST_CTX};
    end else begin
      taken_r <= take; // [R17]
      halt_r <= halt_pend; // [R1] [R18]
      if (halt_pend) begin
        new_level_r <= `IPD_LVL_HALT; // [R19]
        saved_r <= ctx_i; // [R19]
      end else if (take) begin
        new_level_r <= off_r.lvl; // [R17]
        saved_r <= ctx_i; // [R17]
      end
    end
  end

  assign int_req_o = state_r == S_OFFER;
  assign int_level_o = off_r.lvl;
  assign int_vector_o = off_r.vec;
  assign int_internal_o = off_r.internal;
  assign taken_o = taken_r;
  assign halt_o = halt_r;
  assign halt_code_o = `IPD_HALT_CODE; // [R1]
  assign new_level_o = new_level_r;
  assign saved_ctx_o = saved_r;

  // ------------------------------------------------------------------
  // Exception classes
  // ------------------------------------------------------------------
  function automatic ipd_class_t classify(input ipd_exc_t c,
                                          input logic ab);
    ipd_class_t r;
    r = '{CAT_SYSFAIL, KIND_ABORT};
    case (c)
      EXC_INT_OVF, EXC_INT_DIV0, EXC_SUBRNG: r = '{CAT_ARITH, KIND_TRAP};
      EXC_FLT_OVF, EXC_FLT_DIV0, EXC_FLT_UNF: r = '{CAT_ARITH, KIND_FAULT};
      EXC_ACV, EXC_TNV, EXC_MOD_CLR: r = '{CAT_MEMMGT, KIND_FAULT}; // [R15]
      EXC_RSV_MODE: r = '{CAT_OPERAND, KIND_FAULT}; // [R14]
      EXC_RSV_OPND: r = '{CAT_OPERAND, ab ? KIND_ABORT : KIND_FAULT}; // [R14]
      EXC_CHMODE: r = '{CAT_INSTR, KIND_TRAP};
      EXC_RSV_INSTR, EXC_EMUL, EXC_XFC, EXC_BPT, EXC_VEC_DIS: begin
        r = '{CAT_INSTR, KIND_FAULT};
      end
      EXC_TRACE: r = '{CAT_TRACE, KIND_FAULT};
      EXC_ISNV, EXC_CONS_ERR: r = '{CAT_SYSFAIL, KIND_HALT};
      default: r = '{CAT_SYSFAIL, KIND_ABORT};
    endcase
    return r;
  endfunction

  logic exc_valid_r;
  ipd_class_t exc_class_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      exc_valid_r <= 1'b0;
      exc_class_r <= '{CAT_ARITH, KIND_TRAP};
    end else begin
      exc_valid_r <= exc_valid_i;
      if (exc_valid_i) begin
        exc_class_r <= classify(exc_code_i, exc_abort_i); // [R16]
      end
    end
  end

  assign exc_valid_o = exc_valid_r;
  assign exc_class_o = exc_class_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_HALT_ENTRY: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) halt_o |-> halt_code_o == 4'h2 &&
    new_level_o == 5'h1f && !int_req_o) // [R1]
    else $error("halt entry wrong");

  AST_HALT_SAVE: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) halt_pend |=> halt_o &&
    saved_ctx_o == $past(ctx_i)) // [R19]
    else $error("halt context not saved");

  AST_HALT_UNBLOCKED: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) $rose(halt_pend) |-> ##[1:2] halt_o) // [R18]
    else $error("halt blocked");

  AST_ABOVE_LEVEL: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) int_req_o |->
    int_level_o > $past(current_priority_level_i)) // [R20]
    else $error("offer not above current level");

  AST_NO_STALE_OFFER: assert property (@(posedge core_clk_i) // [R20]
    disable iff (!arst_n_i) taken_o || halt_o |=> !int_req_o)
    else $error("offer made before level update");

  AST_VEC_1D: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) $rose(int_req_o) && $past(|pend_1d) |->
    int_level_o == 5'h1d && int_vector_o == 10'h060) // [R2]
    else $error("1D offer wrong");

  AST_VEC_1A: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) int_req_o && int_level_o == 5'h1a |->
    int_vector_o == 10'h054 && !int_internal_o) // [R6]
    else $error("1A offer wrong");

  AST_PERF_INTERNAL: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) int_req_o && int_level_o == 5'h1b |->
    int_internal_o && int_vector_o == 10'h000) // [R12]
    else $error("monitor offer not internal");

  AST_TIMER_YIELDS: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) int_req_o && int_vector_o == 10'h0c0 |->
    !$past(irq_lvl[2])) // [R13]
    else $error("timer beat request line 2");

  AST_TAKE_LEVEL: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) take |=> taken_o && !int_req_o &&
    new_level_o == $past(int_level_o) &&
    saved_ctx_o == $past(ctx_i)) // [R17]
    else $error("take did not raise level");

  AST_MEMMGT_FAULT: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) exc_valid_i && exc_code_i == EXC_TNV |=>
    exc_class_o.cat == CAT_MEMMGT &&
    exc_class_o.kind == KIND_FAULT) // [R15]
    else $error("memory management not fault");

  AST_RSV_OPERAND: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) exc_valid_i && exc_code_i == EXC_RSV_OPND
    |=> exc_class_o.kind == ($past(exc_abort_i) ? KIND_ABORT :
    KIND_FAULT)) // [R14]
    else $error("reserved operand kind wrong");

endmodule

// *** core/ipd_src_cell.sv ***
// Synchronised request source: level or sticky edge-caught pending
`timescale 1ns/10ps
module ipd_src_cell #(
  parameter int W = 1,
  parameter bit STICKY = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] raw_i,
  input wire logic clr_i,
  output logic [W-1:0] pend_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] pend_r;
  logic [W-1:0] pend_nxt;
  logic [W-1:0] rise;

  assign rise = s2_r & ~s3_r;
  // Set wins over clear so an event in the clearing cycle survives
  assign pend_nxt = STICKY ? ((pend_r & ~{W{clr_i}}) | rise) : s2_r;
  assign pend_o = pend_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pend_r <= '0;
    end else begin
      s1_r <= raw_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pend_r <= pend_nxt;
    end
  end
endmodule

// *** include/ipd_cfg.svh ***
// Constants of the interrupt priority and vector dispatch block
//
// Overview of operation
// R1: External halt is nonmaskable, code 2, no vector
// R2: Illegal-length or reserved-command write gives 1D/60
// R3: Disown write timeout or unowned target 1D/60
// R4: Write nonexistent location, parity, timeout: 1D/60
// R5: Backup cache ECC or read-for-write error 1D/60
// R6: Main memory and ownership-bit errors give 1A/54
// R7: Read disown timeout, unacknowledged return: 1A/54
// R8: Cache, instruction cache, bus data parity 1A/54
// R9: Backup cache address and ECC errors 1A/54
// R10: Other illegal length or reserved command 1A/54
// R11: I/O read error line, parity, timeout 1A/54
// R12: Performance monitor at 1B handled internally
// R13: Timer vector C0; request line 2 wins
// R14: Reserved mode fault; reserved operand fault/abort
// R15: Memory management violations are faults
// R16: Exceptions fall into six categories
// R17: Take saves context, raises level, vectors
// R18: Priority level never blocks the halt
// R19: Halt saves context, code, sets level 1F
// R20: Take only above current level, highest first
`ifndef IPD_CFG_SVH
`define IPD_CFG_SVH

// ------------------------------------------------------------------
// Source widths
// ------------------------------------------------------------------
`define IPD_N1D 10
`define IPD_N1A 18

// ------------------------------------------------------------------
// Priority levels
// ------------------------------------------------------------------
`define IPD_LVL_HALT 5'h1f
`define IPD_LVL_1D 5'h1d
`define IPD_LVL_PERF 5'h1b
`define IPD_LVL_1A 5'h1a
`define IPD_LVL_IRQ3 5'h17
`define IPD_LVL_IRQ2 5'h16
`define IPD_LVL_TIMER 5'h16
`define IPD_LVL_IRQ1 5'h15
`define IPD_LVL_IRQ0 5'h14
`define IPD_LVL_NET 5'h13
`define IPD_LVL_NONE 5'h00

// ------------------------------------------------------------------
// Vector offsets and halt code
// ------------------------------------------------------------------
`define IPD_VEC_NONE 10'h000
`define IPD_VEC_1D 10'h060
`define IPD_VEC_1A 10'h054
`define IPD_VEC_TIMER 10'h0c0
`define IPD_VEC_NET 10'h104
`define IPD_VEC_SW_BASE 10'h080
`define IPD_HALT_CODE 4'h2
`define IPD_RST_CTX 32'h0000_0000

`endif

// *** include/ipd_pkg.sv ***
// Types of the interrupt priority and vector dispatch block
package ipd_pkg;

  typedef enum logic [3:0] {
    SRC_NONE, SRC_1D, SRC_PERF, SRC_1A, SRC_IRQ3, SRC_IRQ2,
    SRC_TIMER, SRC_IRQ1, SRC_IRQ0, SRC_NET, SRC_SW
  } ipd_src_t;

  typedef struct packed {
    logic [4:0] lvl;
    logic [9:0] vec;
    logic internal;
    ipd_src_t src;
  } ipd_offer_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] psw;
  } ipd_ctx_t;

  typedef enum logic [4:0] {
    EXC_INT_OVF, EXC_INT_DIV0, EXC_SUBRNG, EXC_FLT_OVF, EXC_FLT_DIV0,
    EXC_FLT_UNF, EXC_ACV, EXC_TNV, EXC_MOD_CLR, EXC_RSV_MODE,
    EXC_RSV_OPND, EXC_RSV_INSTR, EXC_EMUL, EXC_XFC, EXC_CHMODE,
    EXC_BPT, EXC_VEC_DIS, EXC_TRACE, EXC_KSNV, EXC_ISNV,
    EXC_CONS_ERR, EXC_MCHK
  } ipd_exc_t;

  typedef enum logic [2:0] {
    CAT_ARITH, CAT_MEMMGT, CAT_OPERAND, CAT_INSTR, CAT_TRACE, CAT_SYSFAIL
  } ipd_cat_t;

  typedef enum logic [1:0] {
    KIND_TRAP, KIND_FAULT, KIND_ABORT, KIND_HALT
  } ipd_kind_t;

  typedef struct packed {
    ipd_cat_t cat;
    ipd_kind_t kind;
  } ipd_class_t;

endpackage
